// ### common/supply_monitor_pkg.sv
// Purpose: constants and carriers for the supply monitor control block
// Assumes: 8-bit register port, 25 MHz sys_clk
// Notes: offsets are word indices on the plain register port
package supply_monitor_pkg;
   localparam int CLK_HZ = 25000000;
   // register offsets
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_IRQ_CTRL = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_MASK = 4'h3;
   // control field positions
   localparam int BIT_LOW_SUPPLY = 5;
   localparam int BIT_DET_EN = 4;
   localparam int BIT_BG_EN = 3;
   // irq control field positions
   localparam int BIT_IRQ_EN = 0;
   localparam int BIT_IRQ_FLAG = 1;
   localparam int BIT_GROUP_EN = 2;
   localparam int BIT_GLOBAL_EN = 3;
   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
   localparam logic [1:0] MASK_RESET = 2'h0;
   // detector settle and interrupt delays, microseconds
   localparam int T_SETTLE_US = 100;
   localparam int T_IRQ_DELAY_US = 45;
   localparam int SETTLE_CYCLES = T_SETTLE_US * (CLK_HZ / 1000000);
   localparam int IRQ_DELAY_CYCLES = T_IRQ_DELAY_US * (CLK_HZ / 1000000);
   localparam int CNT_W = 12;
   typedef enum logic [1:0] {DET_OFF, DET_SETTLE, DET_ARMED} det_state_e;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
endpackage

// ### rtl/supply_monitor_ctrl.sv
// Purpose: control and status of a supply low-voltage detector
// Assumes: comparator output synchronous to sys_clk; power modes given as levels
// Notes: status sticky bits: 0 = irq flag raised, 1 = detector settled
//        map: 0 control, 1 irq control, 2 status (clear on read), 3 mask
//        low-supply flag reads zero while the detector is off or asleep
//        one counter times the settle and then the low-supply run
//        irq flag sets once per low episode; a rise back above the threshold rearms it
//        software may set the irq flag itself; the wake-up still fires on the hardware set
//
// How it works
// R1: three-bit select picks one of eight thresholds from 2.0 V to 4.0 V
// R2: read-only low-supply flag at control bit 5, high while supply below threshold
// R3: enable bit 4 switches detector on, clearing it switches off
// R4: bandgap on when bit 3 set, or detector or low-voltage reset enabled
// R5: control bits 7 and 6 read zero
// R6: sleep forces detector off even with enable set
// R7: software waits the settle time before trusting the flag
// R8: flag may chatter near threshold; logic tolerates repeated edges
// R9: irq flag rises only after a fixed delay past the flag rising
// R10: in idle with enable set detector runs, irq flag wakes device
// R11: software sets irq flag before idle to suppress wake-up; here wake_request ignores the flag
// R12: request is one source of a shared group, own enable and flag
// R13: request reaches cpu only with own, group and global enables set
`timescale 1ns/10ps
module supply_monitor_ctrl (
   input wire logic sys_clk,
   input wire logic reset,
   input wire supply_monitor_pkg::reg_req_s req,
   output logic [7:0] rdata,
   input wire logic comparator_low,
   input wire logic sleep_mode,
   input wire logic idle_mode,
   input wire logic low_voltage_reset_en,
   output logic [2:0] threshold_select,
   output logic detector_power,
   output logic bandgap_on,
   output logic detector_irq_req,
   output logic wake_request,
   output logic irq
);
   logic [2:0] threshold_q;
   logic bandgap_en_q;
   logic det_en_q;
   logic [7:0] irq_ctrl_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic low_supply_q;
   logic [supply_monitor_pkg::CNT_W-1:0] cnt_q;
   supply_monitor_pkg::det_state_e state_q;
   logic det_on;
   logic wr_ctrl;
   logic wr_irq;
   logic irq_set;
   logic settle_done;
   logic irq_done;
   logic wr_mask;
   logic rd_ctrl;
   logic rd_irq;
   logic rd_status;
   logic rd_mask;
   logic status_clr;
   logic [1:0] status_set;
   logic irq_gate;
   logic bandgap_demand;
   logic wake_event;
   logic low_supply_d;
   logic [7:0] rdata_d;

   // detector runs when enabled and not asleep; idle keeps it running
   assign det_on = det_en_q & ~sleep_mode; // [R3] [R6] [R10]
   assign wr_ctrl = req.wr && req.addr == supply_monitor_pkg::ADDR_CONTROL;
   assign wr_irq = req.wr && req.addr == supply_monitor_pkg::ADDR_IRQ_CTRL;
   assign irq_set = state_q == supply_monitor_pkg::DET_ARMED && low_supply_q && det_on
      && cnt_q == supply_monitor_pkg::CNT_W'(supply_monitor_pkg::IRQ_DELAY_CYCLES); // [R9]
   assign settle_done = state_q == supply_monitor_pkg::DET_SETTLE
      && cnt_q == supply_monitor_pkg::CNT_W'(supply_monitor_pkg::SETTLE_CYCLES);
   assign irq_done = state_q == supply_monitor_pkg::DET_ARMED
      && cnt_q == supply_monitor_pkg::CNT_W'(supply_monitor_pkg::IRQ_DELAY_CYCLES + 1);

   // remaining register decodes
   assign wr_mask = req.wr && req.addr == supply_monitor_pkg::ADDR_MASK;
   assign rd_ctrl = req.rd && req.addr == supply_monitor_pkg::ADDR_CONTROL;
   assign rd_irq = req.rd && req.addr == supply_monitor_pkg::ADDR_IRQ_CTRL;
   assign rd_status = req.rd && req.addr == supply_monitor_pkg::ADDR_STATUS;
   assign rd_mask = req.rd && req.addr == supply_monitor_pkg::ADDR_MASK;

   // status events and their clear
   assign status_clr = rd_status;
   assign status_set = {settle_done, irq_set};

   // request gate: own enable, flag, group and global enables
   assign irq_gate = irq_ctrl_q[supply_monitor_pkg::BIT_IRQ_EN]
      & irq_ctrl_q[supply_monitor_pkg::BIT_IRQ_FLAG]
      & irq_ctrl_q[supply_monitor_pkg::BIT_GROUP_EN]
      & irq_ctrl_q[supply_monitor_pkg::BIT_GLOBAL_EN]; // [R12] [R13]

   // bandgap demand: own bit, running detector or the reset function
   assign bandgap_demand = bandgap_en_q | det_on | low_voltage_reset_en; // [R4]

   // wake only from idle, once per raised flag
   assign wake_event = idle_mode & irq_set; // [R10]

   // comparator seen only while the detector is powered
   assign low_supply_d = det_on & comparator_low; // [R2]

   // threshold select field
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         threshold_q <= supply_monitor_pkg::CONTROL_RESET[2:0];
      end else if (wr_ctrl) begin
         threshold_q <= req.wdata[2:0]; // [R1]
      end
   end

   // bandgap output enable bit
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bandgap_en_q <= supply_monitor_pkg::CONTROL_RESET[supply_monitor_pkg::BIT_BG_EN];
      end else if (wr_ctrl) begin
         bandgap_en_q <= req.wdata[supply_monitor_pkg::BIT_BG_EN]; // [R4]
      end
   end

   // detector enable bit; write bits 7 to 5 are dropped
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         det_en_q <= supply_monitor_pkg::CONTROL_RESET[supply_monitor_pkg::BIT_DET_EN];
      end else if (wr_ctrl) begin
         det_en_q <= req.wdata[supply_monitor_pkg::BIT_DET_EN]; // [R3] [R5]
      end
   end

   // low-supply flag follows comparator only while detector on
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         low_supply_q <= 1'b0;
      end else begin
         low_supply_q <= low_supply_d; // [R2]
      end
   end

   // detector sequencing: off, settling, armed; sleep or disable drops to off
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= supply_monitor_pkg::DET_OFF;
      end else if (!det_on) begin
         state_q <= supply_monitor_pkg::DET_OFF; // [R3] [R6]
      end else begin
         case (state_q)
            supply_monitor_pkg::DET_OFF: begin
               state_q <= supply_monitor_pkg::DET_SETTLE;
            end
            supply_monitor_pkg::DET_SETTLE: begin
               if (settle_done) begin
                  state_q <= supply_monitor_pkg::DET_ARMED;
               end
            end
            default: begin
               state_q <= supply_monitor_pkg::DET_ARMED;
            end
         endcase
      end
   end

   // shared counter: settle time first, then the low-supply run length
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (!det_on) begin
         cnt_q <= '0;
      end else begin
         case (state_q)
            supply_monitor_pkg::DET_OFF: begin
               cnt_q <= '0;
            end
            supply_monitor_pkg::DET_SETTLE: begin
               if (settle_done) begin
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: begin
               if (!low_supply_q) begin
                  cnt_q <= '0; // [R8]
               end else if (!irq_done) begin
                  cnt_q <= cnt_q + 1'b1; // stops one past the delay: one set per episode
               end
            end
         endcase
      end
   end

   // irq control: own enable, hardware-set flag, group and global enables
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq_ctrl_q <= supply_monitor_pkg::IRQ_CTRL_RESET;
      end else begin
         if (wr_irq) begin
            irq_ctrl_q <= {4'h0, req.wdata[3:0]}; // [R11] [R12]
         end
         if (irq_set) begin
            irq_ctrl_q[supply_monitor_pkg::BIT_IRQ_FLAG] <= 1'b1; // [R9] [R10]
         end
      end
   end

   // sticky status, one flop per event; a read clears, a same-cycle set wins
   for (genvar i = 0; i < 2; i++) begin : g_status
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            status_q[i] <= 1'b0;
         end else if (status_set[i]) begin
            status_q[i] <= 1'b1;
         end else if (status_clr) begin
            status_q[i] <= 1'b0;
         end
      end
   end

   // interrupt mask
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mask_q <= supply_monitor_pkg::MASK_RESET;
      end else if (wr_mask) begin
         mask_q <= req.wdata[1:0];
      end
   end

   // read mux, zero when no read or the index is unmapped
   always_comb begin
      rdata_d = 8'h00;
      if (rd_ctrl) begin
         rdata_d = {2'h0, low_supply_q, det_en_q, bandgap_en_q, threshold_q}; // [R2] [R5]
      end else if (rd_irq) begin
         rdata_d = irq_ctrl_q;
      end else if (rd_status) begin
         rdata_d = {6'h00, status_q};
      end else if (rd_mask) begin
         rdata_d = {6'h00, mask_q};
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rdata_d;
      end
   end

   // threshold select to the analog side
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         threshold_select <= 3'h0;
      end else begin
         threshold_select <= threshold_q; // [R1]
      end
   end

   // detector power switch
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         detector_power <= 1'b0;
      end else begin
         detector_power <= det_on; // [R3] [R6]
      end
   end

   // bandgap reference switch
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bandgap_on <= 1'b0;
      end else begin
         bandgap_on <= bandgap_demand; // [R4]
      end
   end

   // gated request into the shared interrupt group
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         detector_irq_req <= 1'b0;
      end else begin
         detector_irq_req <= irq_gate; // [R12] [R13]
      end
   end

   // one-cycle wake pulse while idle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wake_request <= 1'b0;
      end else begin
         wake_request <= wake_event; // [R10]
      end
   end

   // level interrupt from unmasked sticky status
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end
endmodule // supply_monitor_ctrl

// ### verification/supply_monitor_asserts.sv
// Purpose: port checker for the supply monitor control block
// Assumes: one sys_clk domain, reset active high
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module supply_monitor_asserts (
   input wire logic sys_clk, input wire logic reset,
   input wire supply_monitor_pkg::reg_req_s req, input wire logic [7:0] rdata,
   input wire logic comparator_low, input wire logic sleep_mode, input wire logic idle_mode,
   input wire logic low_voltage_reset_en, input wire logic [2:0] threshold_select,
   input wire logic detector_power, input wire logic bandgap_on,
   input wire logic detector_irq_req, input wire logic wake_request, input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic [11:0] low_n_q;
   // run length of a low supply while the detector is on
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) low_n_q <= 12'h000;
      else if (!(comparator_low && detector_power)) low_n_q <= 12'h000;
      else if (low_n_q != 12'hFFF) low_n_q <= low_n_q + 12'h001;
   end
   sequence ctl_wr_s;
      req.wr && req.addr == supply_monitor_pkg::ADDR_CONTROL;
   endsequence
   sequence ctl_rd_off_s;
      req.rd && req.addr == 4'h0 && !detector_power && !$past(detector_power);
   endsequence
   thr_copy_a: assert property (ctl_wr_s ##1 !req.wr |->
      ##1 threshold_select == $past(req.wdata[2:0], 2)) else $error("threshold copy wrong");
   sleep_off_a: assert property (sleep_mode |=> !detector_power)
      else $error("detector on in sleep");
   lvr_bg_a: assert property (low_voltage_reset_en |=> bandgap_on)
      else $error("bandgap off with reset function on");
   rd_idle_a: assert property (!req.rd |=> rdata == 8'h00) else $error("read data not idle");
   rd_top_a: assert property (req.rd |=> rdata[7:6] == 2'h0)
      else $error("upper bits not zero");
   irq_delay_a: assert property ($rose(detector_irq_req) && !$past(req.wr) &&
      !$past(req.wr, 2) |-> low_n_q >= 12'h3E8) else $error("request too early");
   wake_pulse_a: assert property (wake_request |-> $past(idle_mode) ##1 !wake_request)
      else $error("wake pulse wrong");
   flag_off_a: assert property (ctl_rd_off_s |=> !rdata[5])
      else $error("low flag set while off");
endmodule // supply_monitor_asserts
bind supply_monitor_ctrl supply_monitor_asserts i_supply_monitor_asserts (.sys_clk(sys_clk),
   .reset(reset), .req(req), .rdata(rdata), .comparator_low(comparator_low),
   .sleep_mode(sleep_mode), .idle_mode(idle_mode), .low_voltage_reset_en(low_voltage_reset_en),
   .threshold_select(threshold_select), .detector_power(detector_power), .bandgap_on(bandgap_on),
   .detector_irq_req(detector_irq_req), .wake_request(wake_request), .irq(irq));

// ### verification/supply_monitor_ctrl_bench.sv
// Purpose: directed bench for the supply monitor control block
// Assumes: clear-on-read status, one-cycle read latency
// Notes: delays run at full length, far below the cycle ceiling
`timescale 1ns/10ps
module supply_monitor_ctrl_bench;
   localparam logic [3:0] CTL = supply_monitor_pkg::ADDR_CONTROL;
   localparam logic [3:0] IRC = supply_monitor_pkg::ADDR_IRQ_CTRL;
   localparam logic [3:0] STA = supply_monitor_pkg::ADDR_STATUS;
   localparam logic [3:0] MSK = supply_monitor_pkg::ADDR_MASK;
   logic sys_clk = 1'b0, reset = 1'b1, low = 1'b0, sleep = 1'b0, idle = 1'b0, low_voltage_reset = 1'b0;
   supply_monitor_pkg::reg_req_s req = '0;
   logic [7:0] rdata;
   logic [2:0] thr;
   logic pwr, bg, ireq, wake, irq;
   logic wake_seen = 1'b0, ireq_q = 1'b0;
   int n_fail = 0, comparisons = 0, cyc = 0, n_rise = 0;
   supply_monitor_ctrl i_supply_monitor_ctrl (.sys_clk(sys_clk), .reset(reset), .req(req),
      .rdata(rdata), .comparator_low(low), .sleep_mode(sleep), .idle_mode(idle),
      .low_voltage_reset_en(low_voltage_reset), .threshold_select(thr), .detector_power(pwr),
      .bandgap_on(bg), .detector_irq_req(ireq), .wake_request(wake), .irq(irq));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // cycle ceiling and wake pulse latch
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (wake === 1'b1) wake_seen <= 1'b1;
      ireq_q <= ireq;
      if (ireq === 1'b1 && ireq_q === 1'b0) n_rise <= n_rise + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         results();
      end
   end
   task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk) req.wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string w);
      @(posedge sys_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk) req.rd <= 1'b0;
      #1 chk(w, rdata, e);
   endtask
   task automatic t_regs();
      rdc(CTL, 8'h00, "control");
      rdc(IRC, 8'h00, "irq ctrl");
      rdc(MSK, 8'h00, "mask");
      rdc(4'hF, 8'h00, "unmapped");
      wr(CTL, 8'hFF);
      rdc(CTL, 8'h1F, "control ro");
      for (int i = 0; i < 8; i++) begin
         wr(CTL, 8'(i));
         tk(2);
         chk("threshold", 8'(thr), 8'(i));
      end
      $display("test regs done");
   endtask
   task automatic t_det();
      wr(CTL, 8'h10);
      tk(2);
      chk("power", 8'(pwr), 8'h01);
      chk("bandgap auto", 8'(bg), 8'h01);
      @(posedge sys_clk) sleep <= 1'b1;
      tk(2);
      chk("sleep power", 8'(pwr), 8'h00);
      @(posedge sys_clk) sleep <= 1'b0;
      wr(CTL, 8'h08);
      tk(2);
      chk("power off", 8'(pwr), 8'h00);
      chk("bandgap bit", 8'(bg), 8'h01);
      wr(CTL, 8'h00);
      @(posedge sys_clk) low_voltage_reset <= 1'b1;
      tk(2);
      chk("bandgap lvr", 8'(bg), 8'h01);
      @(posedge sys_clk) low_voltage_reset <= 1'b0;
      $display("test detector done");
   endtask
   task automatic t_irq();
      wr(MSK, 8'h01);
      wr(IRC, 8'h0D);
      wr(CTL, 8'h10);
      tk(supply_monitor_pkg::SETTLE_CYCLES + 10);
      // short dip restarts the delay count
      @(posedge sys_clk) low <= 1'b1;
      tk(50);
      @(posedge sys_clk) low <= 1'b0;
      @(posedge sys_clk) low <= 1'b1;
      @(posedge sys_clk) idle <= 1'b1;
      rdc(CTL, 8'h30, "low flag");
      tk(supply_monitor_pkg::IRQ_DELAY_CYCLES - 20);
      chk("early req", 8'(ireq), 8'h00);
      for (int n = 0; n < 100 && ireq !== 1'b1; n++) tk(1);
      chk("late req", 8'(ireq), 8'h01);
      tk(2);
      chk("wake", 8'(wake_seen), 8'h01);
      chk("irq out", 8'(irq), 8'h01);
      rdc(STA, 8'h03, "status");
      tk(1);
      chk("irq cleared", 8'(irq), 8'h00);
      rdc(STA, 8'h00, "status clear");
      wr(IRC, 8'h0B);
      tk(2);
      chk("group off", 8'(ireq), 8'h00);
      $display("test irq done");
   endtask
   task automatic t_quiet();
      int base;
      @(posedge sys_clk) low <= 1'b0;
      @(posedge sys_clk) idle <= 1'b0;
      wr(IRC, 8'h0F);
      tk(3);
      base = n_rise;
      @(posedge sys_clk) idle <= 1'b1;
      @(posedge sys_clk) low <= 1'b1;
      tk(supply_monitor_pkg::IRQ_DELAY_CYCLES + 20);
      chk("quiet rises", 8'(n_rise - base), 8'h00);
      chk("quiet flag", 8'(ireq), 8'h01);
      rdc(STA, 8'h01, "quiet status");
      $display("test quiet done");
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      t_regs();
      t_det();
      t_irq();
      t_quiet();
      results();
   end
endmodule // supply_monitor_ctrl_bench
